// ==== src/tpw_timer_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TPW_TIMER_REGS_VH
`define TPW_TIMER_REGS_VH

// -----------------------------------------------------------------
// Byte offsets on the register bus
// -----------------------------------------------------------------
`define TPW_OFF_PRE_CTRL    8'h00
`define TPW_OFF_PRE_RELOAD  8'h04
`define TPW_OFF_T1_CTRL     8'h08
`define TPW_OFF_T2_CTRL     8'h0C
`define TPW_OFF_T3_CTRL     8'h10
`define TPW_OFF_T4_CTRL     8'h14
`define TPW_OFF_AUX_CTRL    8'h18
`define TPW_OFF_T1_RELOAD   8'h1C
`define TPW_OFF_T2_RELOAD   8'h20
`define TPW_OFF_T3_RELOAD   8'h24
`define TPW_OFF_T4_RELOAD   8'h28
`define TPW_OFF_T4_RELOAD_HI 8'h2C
`define TPW_OFF_COUNTS      8'h30
`define TPW_OFF_WDG         8'h34
`define TPW_OFF_IRQ_STATUS  8'h38
`define TPW_OFF_IRQ_ENABLE  8'h3C
`define TPW_OFF_IRQ_CLEAR   8'h40

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define TPW_PRE_RUN_BIT     0
`define TPW_TMR_SRC_LSB     0
`define TPW_TMR_RUN_BIT     2
`define TPW_T2_PIN_A_SEL    3
`define TPW_AUX_PIN_A_OE    0
`define TPW_AUX_PIN_B_OE    1
`define TPW_AUX_PIN_B_SEL   2
`define TPW_AUX_T1_GATE     3
`define TPW_AUX_T3_GATE     4
`define TPW_AUX_PWM_MODE    5
`define TPW_WDG_FLAG_BIT    16

// -----------------------------------------------------------------
// Reset values and widths
// -----------------------------------------------------------------
`define TPW_CTRL_RESET      4'h0
`define TPW_AUX_RESET       6'h00
`define TPW_RELOAD_RESET    8'hFF
`define TPW_CTRL_W          4
`define TPW_AUX_W           6

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define TPW_CLK_NS          100
`define TPW_INST_DIV        2'd3
`define TPW_WDG_RATIO       65534

`endif

// ==== src/tpw_timer8.v ====
// Eight-bit reloadable down counter shared by the prescaler and the four timers
`timescale 1ns/1ns
`default_nettype none

module tpw_timer8
(
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       run,
  input  wire       tick,
  input  wire       load,
  input  wire [7:0] reload_value,
  output reg  [7:0] count_reg,
  output reg        underflow_reg
);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg     <= 8'hFF;
      underflow_reg <= 1'b0;
    end
    else
    begin
      underflow_reg <= 1'b0;
      if (load)
      begin
        count_reg <= reload_value;
      end
      else if (run && tick)
      begin
        if (count_reg == 8'h00)
        begin
          count_reg     <= reload_value;
          underflow_reg <= 1'b1;
        end
        else
        begin
          count_reg <= count_reg - 8'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== src/tpw_timer_top.v ====
// Prescaler, four timers (timer one chains into two, two into three), PWM, counter pins and watchdog behind an AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "tpw_timer_regs.vh"

module tpw_timer_top
#(
  parameter WDG_RATIO = `TPW_WDG_RATIO
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        crystal_input,
  input  wire        counter_pin_a_in,
  output reg         counter_pin_a_out,
  output wire        counter_pin_a_oe,
  input  wire        counter_pin_b_in,
  output reg         counter_pin_b_out,
  output wire        counter_pin_b_oe,
  input  wire        ext_irq_input_a,
  input  wire        ext_irq_input_b,
  output reg         pwm_signal,
  output reg         system_reset_req,
  output wire        irq
);

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  reg                  pre_run_reg;
  reg [7:0]            pre_reload_reg;
  reg [`TPW_CTRL_W-1:0] t1_ctrl_reg;
  reg [`TPW_CTRL_W-1:0] t2_ctrl_reg;
  reg [`TPW_CTRL_W-1:0] t3_ctrl_reg;
  reg [`TPW_CTRL_W-1:0] t4_ctrl_reg;
  reg [`TPW_AUX_W-1:0]  aux_reg;
  reg [7:0]            t1_reload_reg;
  reg [7:0]            t2_reload_reg;
  reg [7:0]            t3_reload_reg;
  reg [7:0]            t4_reload_reg;
  reg [7:0]            t4_reload_hi_reg;
  reg [3:0]            irq_status_reg;
  reg [3:0]            irq_enable_reg;
  reg                  watchdog_flag;
  reg [15:0]           wdg_count_reg;

  reg                  wr_pend_reg;
  reg [7:0]            wr_addr_reg;
  reg [31:0]           rd_value;

  wire [7:0]           pre_count;
  wire [7:0]           t1_count;
  wire [7:0]           t2_count;
  wire [7:0]           t3_count;
  wire [7:0]           t4_count;
  wire                 prescaler_out;
  wire                 timer_one_underflow;
  wire                 timer_two_underflow;
  wire                 t3_udf;
  wire                 t4_udf;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function pick4;
    input [1:0] sel;
    input       s0;
    input       s1;
    input       s2;
    input       s3;
    begin
      case (sel)
        2'h0:    pick4 = s0;
        2'h1:    pick4 = s1;
        2'h2:    pick4 = s2;
        default: pick4 = s3;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // -----------------------------------------------------------------
  wire accept = hsel && hready && htrans[1];
  wire wr_now = wr_pend_reg;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function wr_hit;
    input [7:0] off;
    begin
      wr_hit = wr_now && (wr_addr_reg == off);
    end
  endfunction

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= accept && hwrite;
      if (accept)
      begin
        wr_addr_reg <= haddr[7:0];
      end
      if (accept && !hwrite)
      begin
        hrdata <= (haddr[31:8] == 24'h000000) ? rd_value : 32'h00000000;
      end
    end
  end

  always @*
  begin
    rd_value = 32'h00000000;
    case (haddr[7:0])
      `TPW_OFF_PRE_CTRL:     rd_value = {31'h00000000, pre_run_reg};
      `TPW_OFF_PRE_RELOAD:   rd_value = {24'h000000, pre_reload_reg};
      `TPW_OFF_T1_CTRL:      rd_value = {28'h0000000, t1_ctrl_reg};
      `TPW_OFF_T2_CTRL:      rd_value = {28'h0000000, t2_ctrl_reg};
      `TPW_OFF_T3_CTRL:      rd_value = {28'h0000000, t3_ctrl_reg};
      `TPW_OFF_T4_CTRL:      rd_value = {28'h0000000, t4_ctrl_reg};
      `TPW_OFF_AUX_CTRL:     rd_value = {26'h0000000, aux_reg};
      `TPW_OFF_T1_RELOAD:    rd_value = {24'h000000, t1_reload_reg};
      `TPW_OFF_T2_RELOAD:    rd_value = {24'h000000, t2_reload_reg};
      `TPW_OFF_T3_RELOAD:    rd_value = {24'h000000, t3_reload_reg};
      `TPW_OFF_T4_RELOAD:    rd_value = {24'h000000, t4_reload_reg};
      `TPW_OFF_T4_RELOAD_HI: rd_value = {24'h000000, t4_reload_hi_reg};
      `TPW_OFF_COUNTS:       rd_value = {t4_count, t3_count, t2_count, t1_count};
      `TPW_OFF_WDG:          rd_value = {15'h0000, watchdog_flag, wdg_count_reg};
      `TPW_OFF_IRQ_STATUS:   rd_value = {28'h0000000, irq_status_reg};
      `TPW_OFF_IRQ_ENABLE:   rd_value = {28'h0000000, irq_enable_reg};
      default:               rd_value = 32'h00000000;
    endcase
  end

  // Control and reload registers: steer the timers; the irq a and irq b pins can also gate timers one and three
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_run_reg      <= 1'b0;
      pre_reload_reg   <= `TPW_RELOAD_RESET;
      t1_ctrl_reg      <= `TPW_CTRL_RESET;
      t2_ctrl_reg      <= `TPW_CTRL_RESET;
      t3_ctrl_reg      <= `TPW_CTRL_RESET;
      t4_ctrl_reg      <= `TPW_CTRL_RESET;
      aux_reg          <= `TPW_AUX_RESET;
      t1_reload_reg    <= `TPW_RELOAD_RESET;
      t2_reload_reg    <= `TPW_RELOAD_RESET;
      t3_reload_reg    <= `TPW_RELOAD_RESET;
      t4_reload_reg    <= `TPW_RELOAD_RESET;
      t4_reload_hi_reg <= `TPW_RELOAD_RESET;
      irq_enable_reg   <= 4'h0;
    end
    else
    begin
      if (wr_hit(`TPW_OFF_PRE_CTRL))     pre_run_reg      <= hwdata[`TPW_PRE_RUN_BIT];
      if (wr_hit(`TPW_OFF_PRE_RELOAD))   pre_reload_reg   <= hwdata[7:0];
      if (wr_hit(`TPW_OFF_T1_CTRL))      t1_ctrl_reg      <= hwdata[`TPW_CTRL_W-1:0];
      if (wr_hit(`TPW_OFF_T2_CTRL))      t2_ctrl_reg      <= hwdata[`TPW_CTRL_W-1:0];
      if (wr_hit(`TPW_OFF_T3_CTRL))      t3_ctrl_reg      <= hwdata[`TPW_CTRL_W-1:0];
      if (wr_hit(`TPW_OFF_T4_CTRL))      t4_ctrl_reg      <= hwdata[`TPW_CTRL_W-1:0];
      if (wr_hit(`TPW_OFF_AUX_CTRL))     aux_reg          <= hwdata[`TPW_AUX_W-1:0];
      if (wr_hit(`TPW_OFF_T1_RELOAD))    t1_reload_reg    <= hwdata[7:0];
      if (wr_hit(`TPW_OFF_T2_RELOAD))    t2_reload_reg    <= hwdata[7:0];
      if (wr_hit(`TPW_OFF_T3_RELOAD))    t3_reload_reg    <= hwdata[7:0];
      if (wr_hit(`TPW_OFF_T4_RELOAD))    t4_reload_reg    <= hwdata[7:0];
      if (wr_hit(`TPW_OFF_T4_RELOAD_HI)) t4_reload_hi_reg <= hwdata[7:0];
      if (wr_hit(`TPW_OFF_IRQ_ENABLE))   irq_enable_reg   <= hwdata[3:0];
    end
  end

  // -----------------------------------------------------------------
  // Pin synchronisers: crystal, pin a, pin b, irq a, irq b
  // -----------------------------------------------------------------
  wire [4:0] pin_raw = {ext_irq_input_b, ext_irq_input_a, counter_pin_b_in,
                        counter_pin_a_in, crystal_input};
  reg  [4:0] sync1_reg;
  reg  [4:0] sync2_reg;
  reg  [4:0] sync3_reg;
  reg  [4:0] pin_level_reg;
  reg  [4:0] pin_rise_reg;
  wire [4:0] pin_level_next = (sync2_reg & sync3_reg) | (pin_level_reg & (sync2_reg | sync3_reg));

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg     <= 5'h00;
      sync2_reg     <= 5'h00;
      sync3_reg     <= 5'h00;
      pin_level_reg <= 5'h00;
      pin_rise_reg  <= 5'h00;
    end
    else
    begin
      sync1_reg     <= pin_raw;
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      pin_level_reg <= pin_level_next;
      pin_rise_reg  <= pin_level_next & ~pin_level_reg;
    end
  end

  wire xtal_tick  = pin_rise_reg[0];
  wire pin_a_tick = pin_rise_reg[1];
  wire pin_b_tick = pin_rise_reg[2];
  wire irq_a_lvl  = pin_level_reg[3];
  wire irq_b_lvl  = pin_level_reg[4];

  // -----------------------------------------------------------------
  // Instruction clock enable from the system clock
  // -----------------------------------------------------------------
  reg [1:0] inst_div_reg;
  reg       instruction_clock;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      inst_div_reg      <= 2'd0;
      instruction_clock <= 1'b0;
    end
    else
    begin
      instruction_clock <= (inst_div_reg == `TPW_INST_DIV - 2'd1);
      inst_div_reg      <= (inst_div_reg == `TPW_INST_DIV - 2'd1) ? 2'd0 : inst_div_reg + 2'd1;
    end
  end

  wire system_clock_signal = 1'b1;

  // -----------------------------------------------------------------
  // Prescaler and timers
  // -----------------------------------------------------------------
  reg  pwm_rise_reg;
  wire t1_run = t1_ctrl_reg[`TPW_TMR_RUN_BIT] && (!aux_reg[`TPW_AUX_T1_GATE] || irq_a_lvl);
  wire t3_run = t3_ctrl_reg[`TPW_TMR_RUN_BIT] && (!aux_reg[`TPW_AUX_T3_GATE] || irq_b_lvl);
  wire t2_run = t2_ctrl_reg[`TPW_TMR_RUN_BIT];
  wire t4_run = t4_ctrl_reg[`TPW_TMR_RUN_BIT];

  wire t1_tick = pick4(t1_ctrl_reg[1:0], instruction_clock, prescaler_out,
                       xtal_tick, pin_a_tick);
  wire t2_tick = pick4(t2_ctrl_reg[1:0], system_clock_signal, prescaler_out,
                       timer_one_underflow, pwm_rise_reg);
  wire t3_tick = pick4(t3_ctrl_reg[1:0], pwm_rise_reg, prescaler_out,
                       timer_two_underflow, pin_b_tick);
  wire t4_tick = t4_ctrl_reg[0] ? prescaler_out : xtal_tick;

  // PWM high period takes the second reload when PWM mode is on
  wire [7:0] t4_reload_sel = (aux_reg[`TPW_AUX_PWM_MODE] && !pwm_signal) ?
                             t4_reload_hi_reg : t4_reload_reg;

  tpw_timer8 u_pre
  (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .run           (pre_run_reg),
    .tick          (instruction_clock),
    .load          (!pre_run_reg),
    .reload_value  (pre_reload_reg),
    .count_reg     (pre_count),
    .underflow_reg (prescaler_out)
  );

  // A reload written while stopped loads the counter with the word being written
  tpw_timer8 u_t1
  (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .run           (t1_run),
    .tick          (t1_tick),
    .load          (wr_hit(`TPW_OFF_T1_RELOAD) && !t1_ctrl_reg[`TPW_TMR_RUN_BIT]),
    .reload_value  (wr_hit(`TPW_OFF_T1_RELOAD) ? hwdata[7:0] : t1_reload_reg),
    .count_reg     (t1_count),
    .underflow_reg (timer_one_underflow)
  );

  tpw_timer8 u_t2
  (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .run           (t2_run),
    .tick          (t2_tick),
    .load          (wr_hit(`TPW_OFF_T2_RELOAD) && !t2_run),
    .reload_value  (wr_hit(`TPW_OFF_T2_RELOAD) ? hwdata[7:0] : t2_reload_reg),
    .count_reg     (t2_count),
    .underflow_reg (timer_two_underflow)
  );

  tpw_timer8 u_t3
  (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .run           (t3_run),
    .tick          (t3_tick),
    .load          (wr_hit(`TPW_OFF_T3_RELOAD) && !t3_ctrl_reg[`TPW_TMR_RUN_BIT]),
    .reload_value  (wr_hit(`TPW_OFF_T3_RELOAD) ? hwdata[7:0] : t3_reload_reg),
    .count_reg     (t3_count),
    .underflow_reg (t3_udf)
  );

  tpw_timer8 u_t4
  (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .run           (t4_run),
    .tick          (t4_tick),
    .load          (wr_hit(`TPW_OFF_T4_RELOAD) && !t4_run),
    .reload_value  (wr_hit(`TPW_OFF_T4_RELOAD) ? hwdata[7:0] : t4_reload_sel),
    .count_reg     (t4_count),
    .underflow_reg (t4_udf)
  );

  // -----------------------------------------------------------------
  // PWM, counter pin outputs
  // -----------------------------------------------------------------
  assign counter_pin_a_oe = aux_reg[`TPW_AUX_PIN_A_OE];
  assign counter_pin_b_oe = aux_reg[`TPW_AUX_PIN_B_OE];
  reg    t3_toggle_reg;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwm_signal        <= 1'b0;
      pwm_rise_reg      <= 1'b0;
      t3_toggle_reg     <= 1'b0;
      counter_pin_a_out <= 1'b0;
      counter_pin_b_out <= 1'b0;
    end
    else
    begin
      pwm_rise_reg <= t4_udf && !pwm_signal;
      if (t4_udf)
        pwm_signal <= !pwm_signal;
      if (t3_udf)
        t3_toggle_reg <= !t3_toggle_reg;
      if (t2_ctrl_reg[`TPW_T2_PIN_A_SEL] ? timer_two_underflow : timer_one_underflow)
        counter_pin_a_out <= !counter_pin_a_out;
      counter_pin_b_out <= aux_reg[`TPW_AUX_PIN_B_SEL] ? t3_toggle_reg : pwm_signal;
    end
  end

  // -----------------------------------------------------------------
  // Interrupt flags: set wins over clear
  // -----------------------------------------------------------------
  wire [3:0] udf_vec = {t4_udf, t3_udf, timer_two_underflow, timer_one_underflow};
  wire [3:0] clr_vec = wr_hit(`TPW_OFF_IRQ_CLEAR) ? hwdata[3:0] : 4'h0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_status_reg <= 4'h0;
    else
      irq_status_reg <= (irq_status_reg & ~clr_vec) | udf_vec;
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // -----------------------------------------------------------------
  // Watchdog: free-running, no control register
  // -----------------------------------------------------------------
  localparam [31:0] WDG_LAST_W = WDG_RATIO - 1;
  localparam [15:0] WDG_LAST   = WDG_LAST_W[15:0];
  wire wdg_done = instruction_clock && (wdg_count_reg == 16'h0000);
  wire wdg_clr  = wr_hit(`TPW_OFF_WDG) && hwdata[`TPW_WDG_FLAG_BIT];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdg_count_reg    <= WDG_LAST;
      watchdog_flag    <= 1'b0;
      system_reset_req <= 1'b0;
    end
    else
    begin
      system_reset_req <= wdg_done && watchdog_flag;
      if (instruction_clock)
        wdg_count_reg <= (wdg_count_reg == 16'h0000) ? WDG_LAST : wdg_count_reg - 16'h0001;
      if (wdg_done)
        watchdog_flag <= 1'b1;
      else if (wdg_clr)
        watchdog_flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== src/tpw_unused_placeholder_never.v ====
// Reserved source file that holds no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== testbench/tpw_timer_top_assertions.sv ====
// Port checker of the timer block
`timescale 1ns/1ns
`default_nettype none
`include "tpw_timer_regs.vh"
module tpw_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        counter_pin_a_oe,
  input wire logic        counter_pin_b_oe,
  input wire logic        counter_pin_b_out,
  input wire logic        pwm_signal,
  input wire logic        system_reset_req,
  input wire logic        irq
);
  logic [7:0] wa_reg;
  logic [5:0] aux_reg;
  logic [3:0] en_reg;
  wire        take = hsel && hready && htrans[1];
  // Shadow of the aux and enable fields, updated at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wa_reg  <= 8'hFF;
      aux_reg <= 6'h00;
      en_reg  <= 4'h0;
    end
    else
    begin
      if (wa_reg == `TPW_OFF_AUX_CTRL)
        aux_reg <= hwdata[5:0];
      if (wa_reg == `TPW_OFF_IRQ_ENABLE)
        en_reg <= hwdata[3:0];
      wa_reg <= (take && hwrite && haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
    end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_unmapped_zero: assert property (take && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_pin_a_oe: assert property (counter_pin_a_oe == aux_reg[`TPW_AUX_PIN_A_OE])
    else $error("pin a enable differs");
  a_pin_b_oe: assert property (counter_pin_b_oe == aux_reg[`TPW_AUX_PIN_B_OE])
    else $error("pin b enable differs");
  a_pin_b_pwm: assert property (!aux_reg[2] && !$past(aux_reg[2]) |-> counter_pin_b_out == $past(pwm_signal))
    else $error("pin b does not follow pwm");
  a_reset_pulse: assert property (system_reset_req |=> !system_reset_req)
    else $error("reset request longer than one cycle");
  a_irq_masked: assert property (en_reg == 4'h0 |-> !irq)
    else $error("irq high while all masked");
endmodule
bind tpw_timer_top tpw_chk tpw_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .counter_pin_a_oe(counter_pin_a_oe),
  .counter_pin_b_oe(counter_pin_b_oe), .counter_pin_b_out(counter_pin_b_out),
  .pwm_signal(pwm_signal), .system_reset_req(system_reset_req), .irq(irq));
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench of the timer block
`timescale 1ns/1ns
`default_nettype none
`include "tpw_timer_regs.vh"
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        xtal = 1'b0;
  logic        pin_a = 1'b0;
  wire         hreadyout;
  wire         pa_out;
  wire         pwm;
  wire         irq;
  wire  [31:0] hrdata;
  wire         srr;
  logic [31:0] q;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          tog = 0;
  int          rise = 0;
  int          i, n, r, k, c;
  tpw_timer_top tpw_timer_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .crystal_input(xtal), .counter_pin_a_in(pin_a), .counter_pin_a_out(pa_out),
    .counter_pin_a_oe(), .counter_pin_b_in(1'b0), .counter_pin_b_out(), .counter_pin_b_oe(),
    .ext_irq_input_a(1'b1), .ext_irq_input_b(1'b1), .pwm_signal(pwm),
    .system_reset_req(srr), .irq(irq));
  always #50 hclk = ~hclk;
  always @(pa_out)
    if (hresetn)
      tog++;
  always @(posedge pwm)
    rise++;
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    cmp(nm, e, q);
  endtask
  // Run timer one from reload n and time the first underflow flag
  task automatic period(input logic [31:0] ctl, input int pr);
    bus(`TPW_OFF_T1_RELOAD, 1'b1, n);
    bus(`TPW_OFF_T1_CTRL, 1'b1, ctl);
    c = 0;
    while (irq !== 1'b1 && c < 5000)
    begin
      @(posedge hclk);
      c++;
    end
    cmp("t1 period", 1, c >= 3 * pr * n && c <= 3 * pr * (n + 1) + 6);
    bus(`TPW_OFF_T1_CTRL, 1'b1, 0);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(15764));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 16; i++)
      if (i != 11 && i != 13)
        chk("reset value", 4 * i, (i == 12) ? 32'hFFFFFFFF :
          (i == 1 || (i > 6 && i < 11)) ? 32'hFF : 32'h0);
    chk("unmapped", 32'h104, 0);
    chk("unmapped", 32'h44, 0);
    bus(`TPW_OFF_WDG, 1'b0, 0);
    c = q[15:0];
    repeat (30) @(posedge hclk);
    bus(`TPW_OFF_WDG, 1'b0, 0);
    cmp("wdg ticks", 1, (c - q[15:0]) inside {[10:11]});
    cmp("wdg flag", 0, q[16]);
    n = $urandom_range(12, 3);
    bus(`TPW_OFF_T1_RELOAD, 1'b1, n);
    chk("t1 load", `TPW_OFF_COUNTS, 32'hFFFFFF00 | n);
    bus(`TPW_OFF_T1_CTRL, 1'b1, 5);
    repeat (60) @(posedge hclk);
    chk("prescaler stopped", `TPW_OFF_COUNTS, 32'hFFFFFF00 | n);
    bus(`TPW_OFF_T1_CTRL, 1'b1, 0);
    bus(`TPW_OFF_IRQ_ENABLE, 1'b1, 1);
    period(4, 1);
    bus(`TPW_OFF_COUNTS, 1'b0, 0);
    k = q;
    repeat (40) @(posedge hclk);
    chk("t1 hold", `TPW_OFF_COUNTS, k);
    chk("status", `TPW_OFF_IRQ_STATUS, 1);
    bus(`TPW_OFF_IRQ_ENABLE, 1'b1, 0);
    @(posedge hclk);
    cmp("irq masked", 0, irq);
    bus(`TPW_OFF_IRQ_ENABLE, 1'b1, 1);
    @(posedge hclk);
    cmp("irq enabled", 1, irq);
    bus(`TPW_OFF_IRQ_CLEAR, 1'b1, 1);
    @(posedge hclk);
    cmp("irq cleared", 0, irq);
    chk("status", `TPW_OFF_IRQ_STATUS, 0);
    r = $urandom_range(3, 1);
    bus(`TPW_OFF_PRE_RELOAD, 1'b1, r);
    bus(`TPW_OFF_PRE_CTRL, 1'b1, 1);
    period(5, r + 1);
    bus(`TPW_OFF_IRQ_CLEAR, 1'b1, 1);
    for (i = 2; i < 4; i++)
    begin
      k = $urandom_range(6, 1);
      bus(`TPW_OFF_T1_RELOAD, 1'b1, 32'hF0);
      bus(`TPW_OFF_T1_CTRL, 1'b1, 4 + i);
      repeat (k)
      begin
        xtal <= (i == 2);
        pin_a <= (i == 3);
        repeat (6) @(posedge hclk);
        xtal <= 1'b0;
        pin_a <= 1'b0;
        repeat (6) @(posedge hclk);
      end
      repeat (8) @(posedge hclk);
      chk("t1 pin count", `TPW_OFF_COUNTS, 32'hFFFFFF00 | (8'hF0 - k));
      bus(`TPW_OFF_T1_CTRL, 1'b1, 0);
    end
    bus(`TPW_OFF_T1_RELOAD, 1'b1, 2);
    bus(`TPW_OFF_T2_RELOAD, 1'b1, 32'h40);
    bus(`TPW_OFF_T3_RELOAD, 1'b1, 32'hF0);
    bus(`TPW_OFF_T4_RELOAD, 1'b1, 1);
    bus(`TPW_OFF_AUX_CTRL, 1'b1, 3);
    bus(`TPW_OFF_T2_CTRL, 1'b1, 6);
    bus(`TPW_OFF_T3_CTRL, 1'b1, 4);
    tog = 0;
    rise = 0;
    bus(`TPW_OFF_T4_CTRL, 1'b1, 5);
    bus(`TPW_OFF_T1_CTRL, 1'b1, 4);
    repeat (200) @(posedge hclk);
    bus(`TPW_OFF_T1_CTRL, 1'b1, 0);
    bus(`TPW_OFF_T4_CTRL, 1'b1, 0);
    repeat (10) @(posedge hclk);
    bus(`TPW_OFF_COUNTS, 1'b0, 0);
    cmp("t2 chained", 8'h40 - tog, q[15:8]);
    cmp("t3 from pwm", 8'hF0 - rise, q[23:16]);
    cmp("wdg reset", 0, srr);
    close_out();
  end
endmodule
`default_nettype wire
